// File: common/uhia_pkg.sv
// constants shared by the usb host interrupt aggregator
package uhia_pkg;
  // ---------------------------------------------
  // register indices (read index, write index)
  // ---------------------------------------------
  localparam logic [7:0] IDX_HWCFG_RD = 8'h20;
  localparam logic [7:0] IDX_HWCFG_WR = 8'ha0;
  localparam logic [7:0] IDX_G2STAT_RD = 8'h03;
  localparam logic [7:0] IDX_G2STAT_WR = 8'h83;
  localparam logic [7:0] IDX_G2EN_RD = 8'h04;
  localparam logic [7:0] IDX_G2EN_WR = 8'h84;
  localparam logic [7:0] IDX_CPUSTAT_RD = 8'h24;
  localparam logic [7:0] IDX_CPUSTAT_WR = 8'ha4;
  localparam logic [7:0] IDX_CPUEN_RD = 8'h25;
  localparam logic [7:0] IDX_CPUEN_WR = 8'ha5;
  localparam logic [7:0] CMD_SOFT_RESET = 8'ha9;
  // ---------------------------------------------
  // field positions
  // ---------------------------------------------
  localparam int HWCFG_PIN_EN_BIT = 0;
  localparam int HWCFG_TRIG_BIT = 1;
  localparam int HWCFG_POL_BIT = 2;
  localparam int G2_MASTER_EN_BIT = 31;
  localparam int CPU_G2_SUMMARY_BIT = 0;
  localparam int EVENT_COUNT = 6;
  // ---------------------------------------------
  // reset values
  // ---------------------------------------------
  localparam logic [2:0] HWCFG_RESET = 3'h0;
  localparam logic [5:0] EVENT_EN_RESET = 6'h00;
  localparam logic INT_PIN_RESET = 1'b1;
endpackage

// File: logic/uhia_event_group.sv
// one group of sticky event flags with enables and an or of the enabled flags
`timescale 1ns/10ps
`default_nettype none
module uhia_event_group #(
  parameter int N = 6
) (
  input wire logic sys_clk, // system clock
  input wire logic clear, // synchronous clear of all flags
  input wire logic [N-1:0] eventIn, // event pulses or levels, one per flag
  input wire logic [N-1:0] clearMask, // one-cycle write-one-to-clear mask
  input wire logic [N-1:0] enable, // enable bit per flag
  output logic [N-1:0] status, // sticky flags
  output logic anyEnabled // or of enabled flags
);
  logic [N-1:0] status_reg;
  logic [N-1:0] status_next;

  // a new event beats a clear in the same cycle
  assign status_next = (status_reg & ~clearMask) | eventIn;
  assign status = status_reg;
  assign anyEnabled = |(status_reg & enable);

  always_ff @(posedge sys_clk) begin
    if (clear) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (clear)
    (status_reg != '0) |=> ((status_reg & $past(status_reg) & ~$past(clearMask))
      == ($past(status_reg) & ~$past(clearMask))))
    else $error("event flag dropped without a clear");
  a_event_caught: assert property (@(posedge sys_clk) disable iff (clear)
    (eventIn != '0) |=> ((status_reg & $past(eventIn)) == $past(eventIn)))
    else $error("event not recorded");
endmodule // uhia_event_group
`default_nettype wire

// File: logic/uhia_irq_aggregator.sv
// interrupt aggregation behind the command and data ports of the host controller
//
// Contract
// - pin trigger and polarity come from config bits 1 and 2; index 20h/a0h.
// - four pin modes: level low, level high, edge low, edge high.
// - config bit 0 is the master enable of the interrupt pin.
// - six group-two events set sticky status bits; enabled ones are ored.
// - group-two or anded with enable bit 31 sets group-two flag in cpu status.
// - group one has six enabled event bits, one fed by group two, ored.
// - pin follows request through a latch; pin enable low holds the pin.
// - reset pin or command a9h returns all control registers to reset values.
`timescale 1ns/10ps
`default_nettype none
module uhia_irq_aggregator
  import uhia_pkg::*;
#(
  parameter int N = EVENT_COUNT
) (
  input wire logic sys_clk, // 20 mhz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic csN, // chip select, active low
  input wire logic addr0, // 1 command port, 0 data port
  input wire logic rdN, // read strobe, active low
  input wire logic wrN, // write strobe, active low
  input wire logic [15:0] dataIn, // data bus from processor
  output logic [15:0] dataOut, // data bus to processor
  output logic dataOe, // drive enable of data bus
  input wire logic [N-1:0] group2Events, // group-two event sources
  input wire logic [N-2:0] group1Events, // other group-one event sources
  output logic intPin // interrupt request pin
);
  // ---------------------------------------------
  // port access decode
  // ---------------------------------------------
  logic wrPrev_reg, rdPrev_reg, phase_reg, dataOe_reg, intPin_reg, reqPrev_reg;
  logic [7:0] index_reg;
  logic [15:0] lowHalf_reg, dataOut_reg;
  logic [31:0] readWord_reg;
  logic [2:0] hwCfg_reg;
  logic [N-1:0] g2Enable_reg, cpuEnable_reg;
  logic g2Master_reg;

  wire wrStart = !csN && !wrN && wrPrev_reg;
  wire rdStart = !csN && !rdN && rdPrev_reg && !addr0;
  wire cmdWrite = wrStart && addr0;
  wire dataWrite = wrStart && !addr0;
  wire softReset = cmdWrite && (dataIn[7:0] == CMD_SOFT_RESET);
  wire ctlClear = rst || softReset;
  wire [31:0] wrWord = {dataIn, lowHalf_reg};
  // 32-bit registers commit only on the upper half
  wire wr16 = dataWrite;
  wire wr32 = dataWrite && phase_reg;

  wire hwCfgWr = wr16 && (index_reg == IDX_HWCFG_WR);
  wire g2StatWr = wr32 && (index_reg == IDX_G2STAT_WR);
  wire g2EnWr = wr32 && (index_reg == IDX_G2EN_WR);
  wire cpuStatWr = wr16 && (index_reg == IDX_CPUSTAT_WR);
  wire cpuEnWr = wr16 && (index_reg == IDX_CPUEN_WR);

  wire pinEnable = hwCfg_reg[HWCFG_PIN_EN_BIT];
  wire edgeMode = hwCfg_reg[HWCFG_TRIG_BIT];
  wire activeHigh = hwCfg_reg[HWCFG_POL_BIT];

  // ---------------------------------------------
  // event groups
  // ---------------------------------------------
  logic [N-1:0] g2Status, cpuStatus;
  logic g2Any, g1Request;
  wire g2Summary = g2Any && g2Master_reg;
  wire [N-1:0] g2Clear = g2StatWr ? wrWord[N-1:0] : '0;
  wire [N-1:0] cpuClear = cpuStatWr ? dataIn[N-1:0] : '0;

  uhia_event_group #(.N(N)) u_group2 (
    .sys_clk(sys_clk),
    .clear(ctlClear),
    .eventIn(group2Events),
    .clearMask(g2Clear),
    .enable(g2Enable_reg),
    .status(g2Status),
    .anyEnabled(g2Any)
  );

  uhia_event_group #(.N(N)) u_group1 (
    .sys_clk(sys_clk),
    .clear(ctlClear),
    .eventIn({group1Events, g2Summary}),
    .clearMask(cpuClear),
    .enable(cpuEnable_reg),
    .status(cpuStatus),
    .anyEnabled(g1Request)
  );

  // ---------------------------------------------
  // read mux
  // ---------------------------------------------
  wire [31:0] readSel =
    (index_reg == IDX_HWCFG_RD) ? {29'h0, hwCfg_reg} :
    (index_reg == IDX_G2STAT_RD) ? {26'h0, g2Status} :
    (index_reg == IDX_G2EN_RD) ? {g2Master_reg, 25'h0, g2Enable_reg} :
    (index_reg == IDX_CPUSTAT_RD) ? {26'h0, cpuStatus} :
    (index_reg == IDX_CPUEN_RD) ? {26'h0, cpuEnable_reg} : 32'h0;

  // ---------------------------------------------
  // pin stage
  // ---------------------------------------------
  // edge modes give a one-cycle pulse on each rise of the request
  wire pinActive = edgeMode ? (g1Request && !reqPrev_reg) : g1Request;
  wire pinLevel = activeHigh ? pinActive : !pinActive;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPrev_reg <= 1'b1;
      rdPrev_reg <= 1'b1;
    end else begin
      wrPrev_reg <= wrN || csN;
      rdPrev_reg <= rdN || csN;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      index_reg <= 8'h00;
      phase_reg <= 1'b0;
      lowHalf_reg <= 16'h0000;
    end else if (cmdWrite) begin
      index_reg <= dataIn[7:0];
      phase_reg <= 1'b0;
    end else if (dataWrite || rdStart) begin
      lowHalf_reg <= dataIn;
      phase_reg <= !phase_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ctlClear) begin
      hwCfg_reg <= HWCFG_RESET;
      g2Enable_reg <= EVENT_EN_RESET;
      g2Master_reg <= 1'b0;
      cpuEnable_reg <= EVENT_EN_RESET;
    end else begin
      if (hwCfgWr) hwCfg_reg <= dataIn[2:0];
      if (g2EnWr) g2Enable_reg <= wrWord[N-1:0];
      if (g2EnWr) g2Master_reg <= wrWord[G2_MASTER_EN_BIT];
      if (cpuEnWr) cpuEnable_reg <= dataIn[N-1:0];
    end
  end

  // read word is frozen at the low half so the two halves agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      readWord_reg <= 32'h0;
      dataOut_reg <= 16'h0000;
      dataOe_reg <= 1'b0;
    end else begin
      dataOe_reg <= !csN && !rdN && !addr0;
      if (rdStart && !phase_reg) begin
        readWord_reg <= readSel;
        dataOut_reg <= readSel[15:0];
      end else if (rdStart) begin
        dataOut_reg <= readWord_reg[31:16];
      end
    end
  end

  // while the pin enable is low the pin and its edge memory are frozen
  always_ff @(posedge sys_clk) begin
    if (ctlClear) begin
      intPin_reg <= INT_PIN_RESET;
      reqPrev_reg <= 1'b0;
    end else if (pinEnable) begin
      intPin_reg <= pinLevel;
      reqPrev_reg <= g1Request;
    end
  end

  assign dataOut = dataOut_reg;
  assign dataOe = dataOe_reg;
  assign intPin = intPin_reg;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_pin_hold: assert property (!pinEnable && !softReset |=> $stable(intPin))
    else $error("pin changed while pin enable low");
  a_level_high: assert property (
    pinEnable && !edgeMode && activeHigh && g1Request && !softReset |=> intPin)
    else $error("level high mode not asserted");
  a_level_low: assert property (
    pinEnable && !edgeMode && !activeHigh && g1Request && !softReset |=> !intPin)
    else $error("level low mode not asserted");
  a_edge_pulse: assert property (
    pinEnable && edgeMode && activeHigh && g1Request && !reqPrev_reg && !softReset
    ##1 pinEnable && edgeMode && activeHigh && !softReset |=> !intPin)
    else $error("edge pulse longer than one cycle");
  a_soft_clear: assert property (softReset |=> hwCfg_reg == HWCFG_RESET
    && intPin == INT_PIN_RESET && g2Status == '0 && cpuStatus == '0)
    else $error("soft reset left state behind");
  a_g2_summary: assert property (
    g2Any && g2Master_reg && !softReset |=> cpuStatus[CPU_G2_SUMMARY_BIT])
    else $error("group two summary not raised");
  a_g2_masked: assert property (
    !g2Master_reg && !cpuStatus[CPU_G2_SUMMARY_BIT] |=> !cpuStatus[CPU_G2_SUMMARY_BIT])
    else $error("summary set without master enable");
  a_cfg_write: assert property (hwCfgWr && !softReset |=> hwCfg_reg == $past(dataIn[2:0]))
    else $error("hardware config write lost");

  c_level_irq: cover property (pinEnable && !edgeMode && g1Request ##1 intPin);
  c_edge_irq: cover property (pinEnable && edgeMode && g1Request && !reqPrev_reg);
  c_soft_reset: cover property (softReset);
  c_g2_path: cover property (g2Summary ##1 g1Request);
endmodule // uhia_irq_aggregator
`default_nettype wire

// File: sim/uhia_cpu_model.sv
// processor model driving the command and data ports of the aggregator
`timescale 1ns/10ps
`default_nettype none
module uhia_cpu_model (
  input wire logic sys_clk, // system clock
  output logic csN, // chip select, active low
  output logic addr0, // 1 command port, 0 data port
  output logic rdN, // read strobe, active low
  output logic wrN, // write strobe, active low
  output logic [15:0] dataIn, // data toward the block
  input wire logic [15:0] dataOut // read data from the block
);
  initial begin
    csN = 1'b1;
    addr0 = 1'b0;
    rdN = 1'b1;
    wrN = 1'b1;
    dataIn = 16'h0000;
  end
  // strobe low for two edges, then high for at least one
  task automatic access(input logic cmd, input logic rd, input logic [15:0] d,
                        output logic [15:0] q);
    @(negedge sys_clk);
    csN = 1'b0;
    addr0 = cmd;
    rdN = ~rd;
    wrN = rd;
    dataIn = d;
    repeat (2) @(negedge sys_clk);
    q = dataOut;
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    // a released bus must not look like the old value
    dataIn = ~d;
    @(negedge sys_clk);
  endtask
endmodule // uhia_cpu_model
`default_nettype wire

// File: sim/test_usb_host_irq_aggregator.sv
// self-checking bench for the usb host interrupt aggregator
`timescale 1ns/10ps
`default_nettype none
module test_usb_host_irq_aggregator;
  import uhia_pkg::*;
  logic sys_clk, rst, csN, addr0, rdN, wrN, dataOe, intPin;
  logic [15:0] dataIn, dataOut, rv;
  logic [5:0] g2Ev;
  logic [4:0] g1Ev;
  logic [2:0] cfg;
  int fail_count, compares, seed, hits, k;
  uhia_irq_aggregator dut_u (.sys_clk(sys_clk), .rst(rst), .csN(csN), .addr0(addr0),
    .rdN(rdN), .wrN(wrN), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .group2Events(g2Ev), .group1Events(g1Ev), .intPin(intPin));
  uhia_cpu_model cpu_u (.sys_clk(sys_clk), .csN(csN), .addr0(addr0), .rdN(rdN),
    .wrN(wrN), .dataIn(dataIn), .dataOut(dataOut));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    cpu_u.access(1'b1, 1'b0, {8'h00, idx}, rv);
    cpu_u.access(1'b0, 1'b0, d, rv);
  endtask
  // drive enable must be up while the read strobe stands and drop after it
  task automatic rd(input logic [7:0] idx);
    cpu_u.access(1'b1, 1'b0, {8'h00, idx}, rv);
    fork
      cpu_u.access(1'b0, 1'b1, 16'h0000, rv);
      begin
        repeat (2) @(negedge sys_clk);
        chk({15'h0000, dataOe}, 16'h0001);
      end
    join
    chk({15'h0000, dataOe}, 16'h0000);
  endtask
  function automatic logic [15:0] exp_hits(input logic [2:0] c);
    return c[1] ? 16'h0001 : 16'h0007; // edge gives one pulse, level holds
  endfunction
  // one-cycle event, then count cycles with the pin at its active level
  task automatic fire(input logic g2, input int n, input logic [2:0] c);
    @(negedge sys_clk);
    if (g2) g2Ev[n] = 1'b1;
    else g1Ev[n] = 1'b1;
    hits = 0;
    repeat (8) begin
      @(negedge sys_clk);
      g1Ev = 5'h00;
      g2Ev = 6'h00;
      if (intPin === c[2]) hits++;
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    g1Ev = 5'h00;
    g2Ev = 6'h00;
    seed = 32'he5f1;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    chk(intPin, 1'b1);
    chk(dataOe, 1'b0);
    rd(IDX_HWCFG_RD);
    chk(rv, 16'h0000);
    wr(IDX_CPUEN_WR, 16'h003f);
    rd(IDX_CPUEN_RD);
    chk(rv, 16'h003f);
    for (int m = 0; m < 4; m++) begin
      cfg = {m[0], m[1], 1'b1};
      wr(IDX_HWCFG_WR, {13'h0000, cfg});
      rd(IDX_HWCFG_RD);
      chk(rv, {13'h0000, cfg});
      chk(intPin, !cfg[2]);
      k = ($random(seed) & 32'h7fffffff) % 5;
      fire(1'b0, k, cfg);
      chk(hits[15:0], exp_hits(cfg));
      rd(IDX_CPUSTAT_RD);
      chk(rv, 16'h0002 << k);
      wr(IDX_CPUSTAT_WR, 16'h003f);
      rd(IDX_CPUSTAT_RD);
      chk(rv, 16'h0000);
    end
    $display("pin modes test done");
    cfg = 3'h5;
    wr(IDX_HWCFG_WR, 16'h0005);
    wr(IDX_G2EN_WR, 16'h003f);
    cpu_u.access(1'b0, 1'b0, 16'h0000, rv);
    k = ($random(seed) & 32'h7fffffff) % 6;
    fire(1'b1, k, cfg);
    chk(hits[15:0], 16'h0000);
    rd(IDX_G2STAT_RD);
    chk(rv, 16'h0001 << k);
    wr(IDX_G2EN_WR, 16'h003f);
    cpu_u.access(1'b0, 1'b0, 16'h8000, rv);
    rd(IDX_CPUSTAT_RD);
    chk(rv, 16'h0001);
    chk(intPin, 1'b1);
    rd(IDX_G2EN_RD);
    chk(rv, 16'h003f);
    cpu_u.access(1'b0, 1'b1, 16'h0000, rv);
    chk(rv, 16'h8000);
    $display("group two test done");
    // group-two flags first, or the summary bit sets again at once
    wr(IDX_HWCFG_WR, 16'h0004);
    wr(IDX_G2STAT_WR, 16'h003f);
    cpu_u.access(1'b0, 1'b0, 16'h0000, rv);
    wr(IDX_CPUSTAT_WR, 16'h003f);
    chk(intPin, 1'b1);
    wr(IDX_HWCFG_WR, 16'h0005);
    chk(intPin, 1'b0);
    fire(1'b0, 0, cfg);
    chk(hits[15:0], 16'h0007);
    wr(IDX_CPUEN_WR, 16'h0000);
    chk(intPin, 1'b0);
    wr(IDX_HWCFG_WR, 16'h0004);
    wr(IDX_CPUEN_WR, 16'h003f);
    chk(intPin, 1'b0);
    wr(IDX_HWCFG_WR, 16'h0005);
    chk(intPin, 1'b1);
    rd(IDX_HWCFG_RD);
    chk(rv, 16'h0005);
    wr(IDX_CPUSTAT_WR, 16'h003f);
    wr(IDX_HWCFG_WR, 16'h0004);
    fire(1'b0, 2, cfg);
    chk(hits[15:0], 16'h0000);
    $display("pin latch test done");
    cpu_u.access(1'b1, 1'b0, {8'h00, CMD_SOFT_RESET}, rv);
    chk(intPin, 1'b1);
    rd(IDX_HWCFG_RD);
    chk(rv, 16'h0000);
    rd(IDX_CPUSTAT_RD);
    chk(rv, 16'h0000);
    $display("soft reset test done");
    // pin driven low before the reset pin so that the reset level shows
    cfg = 3'h1;
    wr(IDX_HWCFG_WR, {13'h0000, cfg});
    wr(IDX_CPUEN_WR, 16'h003f);
    fire(1'b0, 1, cfg);
    chk(hits[15:0], 16'h0007);
    chk({15'h0000, intPin}, 16'h0000);
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    chk({15'h0000, intPin}, 16'h0001);
    rd(IDX_HWCFG_RD);
    chk(rv, 16'h0000);
    rd(IDX_CPUSTAT_RD);
    chk(rv, 16'h0000);
    rd(IDX_CPUEN_RD);
    chk(rv, 16'h0000);
    $display("hardware reset test done");
    tally_and_finish();
  end
endmodule // test_usb_host_irq_aggregator
`default_nettype wire
